// ### hw/wdt_pkg.sv
package wdt_pkg;

  // ****************************************
  // register map
  // ****************************************
  // printed offset is not word aligned, so it is an index
  localparam logic [7:0] CTL_INDEX = 8'h21;
  localparam logic [11:0] CTL_ADDR = {2'h0, CTL_INDEX, 2'h0};
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  localparam int ENABLE_BIT = 3;
  localparam int TURNOFF_BIT = 4;
  localparam int CTL_W = 5;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [2:0] TURNOFF_CYCLES = 3'h4;
  // shortest period in watchdog oscillator ticks (16K)
  localparam int unsigned BASE_TICKS = 16384;
  localparam int CNT_W = 22;

endpackage

// ### hw/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter #(
  parameter int unsigned BASE = wdt_pkg::BASE_TICKS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // control
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic [2:0] sel_i,
  // status
  output logic expire_o
);

  typedef struct packed {
    logic [wdt_pkg::CNT_W-1:0] cnt;
    logic expire;
  } cnt_state_t;

  cnt_state_t s_r;
  cnt_state_t s_nxt;
  logic [wdt_pkg::CNT_W-1:0] last;
  localparam logic [wdt_pkg::CNT_W-1:0] BASE_C = BASE[wdt_pkg::CNT_W-1:0];

  // ****************************************
  // period select: each code doubles the period
  // ****************************************
  assign last = (BASE_C << sel_i) - 22'h000001; // R4

  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (clear_i) begin
      s_nxt.cnt = '0; // R2
    end else if (enable_i && tick_i) begin // R1 R5
      if (s_r.cnt >= last) begin
        s_nxt.cnt = '0;
        s_nxt.expire = 1'b1; // R3
      end else begin
        s_nxt.cnt = s_r.cnt + 22'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire_o = s_r.expire;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_tick_only;
    !tick_i && !clear_i |=> $stable(s_r.cnt);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved without tick"); // R1

  property p_kick;
    clear_i |=> s_r.cnt == '0 && !s_r.expire;
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not restart count"); // R2

  property p_period;
    enable_i && tick_i && !clear_i && s_r.cnt == last |=> s_r.expire;
  endproperty
  a_period: assert property (p_period) else $error("missed period end"); // R4

  property p_disabled;
    !enable_i && !clear_i |=> $stable(s_r.cnt) && !s_r.expire;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled but counting"); // R5

  c_expire: cover property (s_r.expire);

endmodule

// ### hw/wdt_top.sv
`timescale 1ns/1ps
// Functional notes
// R1 - counter advances only on ticks of its own oscillator, not cpu clock
// R2 - kick instruction restarts the count from zero
// R3 - enabled watchdog reaching period end resets the device
// R4 - select code 000 gives 16K ticks, each step doubles, up to 2048K
// R5 - watchdog runs while enable is one, idle while zero
// R6 - clearing enable works only while turn-off enable is one
// R7 - hardware clears turn-off enable four cycles after it is set
// R8 - software starts a disable by writing both bits one together
// R9 - software writes enable zero within four cycles to finish disabling
// R10 - bits 7..5 of control ignore writes and read zero
// R11 - software should kick before enabling; else first period may be short
// R12 - enabled watchdog keeps counting in sleep and its reset wakes device
// R13 - watchdog reset clears control register and restarts the counter
module wdt_top #(
  parameter int unsigned BASE_TICKS = wdt_pkg::BASE_TICKS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // core side
  input wire logic osc_tick_i,
  input wire logic kick_instruction_i,
  input wire logic sleep_i,
  output logic wdt_reset_o
);

  typedef struct packed {
    logic en;
    logic toe;
    logic [2:0] sel;
    logic [2:0] toe_cnt;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic wdt_rst;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;
  logic hit;
  logic wr_acc;
  logic expire;

  // ****************************************
  // apb decode
  // ****************************************
  assign hit = paddr_i == wdt_pkg::CTL_ADDR;
  // writes land only at the edge where pready is seen high
  assign wr_acc = psel_i && penable_i && s_r.ready && pwrite_i && hit;

  // ****************************************
  // period counter
  // ****************************************
  // sleep is deliberately not an input: counting goes on in sleep
  wdt_counter #(
    .BASE(BASE_TICKS)
  ) u_counter (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_i(osc_tick_i), // R1
    .enable_i(s_r.en), // R5 R12
    .clear_i(kick_instruction_i || s_r.wdt_rst), // R2 R13
    .sel_i(s_r.sel),
    .expire_o(expire)
  );

  // ****************************************
  // control register and bus answer
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = psel_i && penable_i && !s_r.ready;
    s_nxt.err = 1'b0;
    s_nxt.rdata = '0;
    s_nxt.wdt_rst = 1'b0;
    if (s_nxt.ready) begin
      if (hit) begin
        s_nxt.rdata = {27'h0, s_r.toe, s_r.en, s_r.sel}; // R10
      end else begin
        s_nxt.err = 1'b1;
      end
    end
    if (s_r.toe) begin
      if (s_r.toe_cnt == 3'h1) begin
        s_nxt.toe = 1'b0; // R7
      end
      s_nxt.toe_cnt = s_r.toe_cnt - 3'h1;
    end
    if (wr_acc) begin
      s_nxt.sel = pwdata_i[wdt_pkg::SEL_LSB +: wdt_pkg::SEL_W];
      if (pwdata_i[wdt_pkg::TURNOFF_BIT]) begin
        s_nxt.toe = 1'b1; // R7
        s_nxt.toe_cnt = wdt_pkg::TURNOFF_CYCLES;
      end
      if (pwdata_i[wdt_pkg::ENABLE_BIT]) begin
        s_nxt.en = 1'b1;
      end else if (s_r.toe) begin
        s_nxt.en = 1'b0; // R6
      end
    end
    // timeout outranks a write in the same cycle
    if (expire) begin
      s_nxt.en = 1'b0; // R13
      s_nxt.toe = 1'b0;
      s_nxt.sel = '0;
      s_nxt.toe_cnt = '0;
      s_nxt.wdt_rst = 1'b1; // R3 R12
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.rdata;
  assign pready_o = s_r.ready;
  assign pslverr_o = s_r.err;
  assign wdt_reset_o = s_r.wdt_rst;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_timeout;
    expire |=> wdt_reset_o && !s_r.en;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout gave no reset"); // R3

  property p_no_clear;
    wr_acc && !pwdata_i[3] && !s_r.toe && s_r.en && !expire |=> s_r.en;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("enable cleared unguarded"); // R6

  property p_clear;
    wr_acc && !pwdata_i[3] && s_r.toe |=> !s_r.en;
  endproperty
  a_clear: assert property (p_clear) else $error("guarded disable ignored"); // R6

  property p_toe_life;
    $rose(s_r.toe) ##0 (!wr_acc)[*4] |=> !s_r.toe;
  endproperty
  a_toe_life: assert property (p_toe_life) else $error("turn-off not timed out"); // R7

  // a timeout inside the window wipes the bit on purpose
  property p_toe_hold;
    $rose(s_r.toe) ##0 (!expire)[*3]
      |-> ($past(s_r.toe) && s_r.toe) ##1 s_r.toe;
  endproperty
  a_toe_hold: assert property (p_toe_hold) else $error("turn-off dropped early"); // R7

  property p_reserved;
    pready_o |-> prdata_o[31:5] == 27'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // R10

  property p_sleep;
    sleep_i && expire |=> wdt_reset_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no reset during sleep"); // R12

  property p_wipe;
    wdt_reset_o |-> !s_r.en && !s_r.toe && s_r.sel == 3'h0;
  endproperty
  a_wipe: assert property (p_wipe) else $error("control not wiped"); // R13

  property p_sel_write;
    wr_acc && !expire |=> s_r.sel == $past(pwdata_i[2:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) // R4
    else $error("select not written");

  property p_enable_set;
    wr_acc && pwdata_i[wdt_pkg::ENABLE_BIT] && !expire |=> s_r.en;
  endproperty
  a_enable_set: assert property (p_enable_set) // R5
    else $error("enable write lost");

  property p_expire_en;
    expire |-> $past(s_r.en);
  endproperty
  a_expire_en: assert property (p_expire_en) // R5
    else $error("expired while disabled");

  property p_kick_clear;
    kick_instruction_i |=> !expire;
  endproperty
  a_kick_clear: assert property (p_kick_clear) // R2
    else $error("expired right after kick");

  property p_rst_pulse;
    wdt_reset_o |=> !wdt_reset_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) // R3
    else $error("reset request not a pulse");

  // only the guarded write or a timeout may drop enable
  property p_en_hold;
    s_r.en && !s_r.toe && !expire |=> s_r.en;
  endproperty
  a_en_hold: assert property (p_en_hold) // R6
    else $error("enable lost without turn-off");

  property p_toe_set;
    wr_acc && pwdata_i[wdt_pkg::TURNOFF_BIT] && !expire
      |=> s_r.toe && s_r.toe_cnt == wdt_pkg::TURNOFF_CYCLES;
  endproperty
  a_toe_set: assert property (p_toe_set) // R7
    else $error("turn-off not armed");

  property p_readback;
    pready_o && !pslverr_o |-> prdata_o[4:0] ==
      {$past(s_r.toe), $past(s_r.en), $past(s_r.sel)};
  endproperty
  a_readback: assert property (p_readback) // R10
    else $error("control readback wrong");

  c_sleep_kick: cover property (sleep_i && kick_instruction_i);
  c_disable: cover property (wr_acc && s_r.toe && !pwdata_i[3]);
  c_reset: cover property (wdt_reset_o);
  c_late: cover property ($fell(s_r.toe) && s_r.en);

endmodule

// ### verification/wdt_top_tb.sv
`timescale 1ns/1ps
module wdt_top_tb;
  localparam int unsigned BT = 4;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic osc_tick_i = 1'b0;
  logic kick_instruction_i = 1'b0;
  logic sleep_i = 1'b0;
  logic wdt_reset_o;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  bit seen;
  logic [2:0] s;

  wdt_top #(.BASE_TICKS(BT)) u_wdt_top (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .osc_tick_i(osc_tick_i), .kick_instruction_i(kick_instruction_i),
    .sleep_i(sleep_i), .wdt_reset_o(wdt_reset_o));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request stays up until pready; caller releases with apb_end
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
  endtask

  task automatic apb_end();
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(logic [31:0] d);
    apb(1'b1, wdt_pkg::CTL_ADDR, d);
    apb_end();
  endtask

  task automatic rd_chk(logic [31:0] e);
    apb(1'b0, wdt_pkg::CTL_ADDR, 32'h0);
    apb_end();
    chk("control", e, rd);
  endtask

  task automatic kick();
    kick_instruction_i <= 1'b1;
    @(posedge clk_sys_i);
    kick_instruction_i <= 1'b0;
  endtask

  task automatic tick_watch(output bit sn);
    sn = 0;
    osc_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    osc_tick_i <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys_i);
      if (wdt_reset_o === 1'b1) sn = 1;
    end
  endtask

  function automatic int unsigned period(logic [2:0] sel);
    return BT << sel;
  endfunction

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(32'h696b738b));
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    rd_chk({24'h0, wdt_pkg::CTL_RESET});
    s = 3'($urandom);
    wr({27'($urandom), 5'h00} | {29'h0, s});
    rd_chk({29'h0, s});
    apb(1'b1, wdt_pkg::CTL_ADDR + 12'h004, $urandom);
    apb_end();
    chk("slverr", 32'h1, {31'h0, er});
    for (int k = 0; k < 10; k++) begin
      tick_watch(seen);
      chk("idle reset", 32'h0, {31'h0, seen});
    end
    for (int k = 0; k < 8; k++) begin
      s = 3'(k);
      kick();
      wr({28'h0, 1'b1, s});
      for (int i = 1; i <= period(s); i++) begin
        tick_watch(seen);
        chk("wdt reset", {31'h0, i == period(s)}, {31'h0, seen});
      end
      rd_chk(32'h0);
    end
    wr(32'h08);
    kick();
    sleep_i <= 1'b1;
    for (int i = 1; i <= 7; i++) begin
      if (i == 4) kick();
      tick_watch(seen);
      chk("kick reset", {31'h0, i == 7}, {31'h0, seen});
    end
    sleep_i <= 1'b0;
    s = 3'($urandom);
    wr({27'h0, 2'h3, s});
    repeat (6) @(posedge clk_sys_i);
    wr({29'h0, s});
    rd_chk({27'h0, 2'h1, s});
    apb(1'b1, wdt_pkg::CTL_ADDR, {27'h0, 2'h3, s});
    apb(1'b1, wdt_pkg::CTL_ADDR, {29'h0, s});
    apb_end();
    rd_chk({29'h0, s});
    report_and_stop();
  end
endmodule
